// >>> pkg/prog_port_pkg.sv
// constants and carrier types for the serial programming host
// assumes a single system clock; the serial clock is divided from it
package prog_port_pkg;

  // system clock and serial clock timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_PERIOD_NS = 1000;
  // one serial clock period is four equal quarters
  localparam int SCK_QUARTER_CYCLES = SCK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // default wait for a self-timed write cycle, used by the wait command
  localparam int WRITE_CYCLE_US = 10000;
  localparam int WRITE_CYCLE_CYCLES = (WRITE_CYCLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bit slots of one byte: eight data bits then the acknowledge slot
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] FIRST_SLOT = 4'h0;

  // quarter phases inside a slot
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // reset values
  localparam logic RST_SCK = 1'b1;
  localparam logic RST_PULL = 1'b0;
  localparam logic RST_SELECT_N = 1'b1;
  localparam logic RST_SYNC = 1'b1;

  typedef enum logic [2:0] {
    OP_START = 3'h0,
    OP_STOP = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_WAIT = 3'h4
  } op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_STOP = 5'h04,
    ST_BYTE = 5'h08,
    ST_WAIT = 5'h10
  } state_t;

  typedef struct packed {
    op_t op;
    logic lsbFirst;
    logic ackRead;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic ackOk;
    logic [7:0] data;
  } resp_t;

endpackage

// >>> verilog/serial_prog_host.sv
// serial programming host: frames start, stop, bytes and acknowledges
// assumes an external pull-up on the data line and a device on the far end
// assumes the far end never drives the clock and only pulls data low
module serial_prog_host #(
  parameter int QUARTER = prog_port_pkg::SCK_QUARTER_CYCLES,
  parameter int WAIT_CYCLES = prog_port_pkg::WRITE_CYCLE_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // user side
  input wire logic progEnable,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire prog_port_pkg::cmd_t cmd,
  output logic respValid,
  output prog_port_pkg::resp_t resp,
  // link pins
  output logic serialProgramSelectN,
  output logic progSerialClock,
  input wire logic progSerialDataIn,
  output logic progSerialDataOut,
  output logic progSerialDataOeN
);

  //////////////////////////////////////////////////////////////////////////////

  // sync needs two cycles and the sample point ends the second high quarter
  if (QUARTER < 3 || QUARTER > 65535) begin : g_bad_quarter
    $error("QUARTER must lie between 3 and 65535");
  end
  if (WAIT_CYCLES < 1 || WAIT_CYCLES > 16777215) begin : g_bad_wait
    $error("WAIT_CYCLES must lie between 1 and 16777215");
  end

  localparam logic [15:0] QUARTER_LAST = 16'(QUARTER - 1);
  localparam logic [23:0] WAIT_LAST = 24'(WAIT_CYCLES - 1);

  typedef struct packed {
    prog_port_pkg::state_t state;
    logic [1:0] phase;
    logic [15:0] cnt;
    logic [23:0] waitCnt;
    logic [3:0] slot;
    logic isWrite;
    logic lsbFirst;
    logic ackRead;
    logic [7:0] shift;
    logic ackOk;
    logic respValid;
    logic sck;
    logic pull;
    logic selectN;
    logic sdaSync1;
    logic sdaSync2;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;

  //////////////////////////////////////////////////////////////////////////////

  // position of the bit carried in a given slot
  function automatic logic [2:0] bitPos(input logic lsbFirst, input logic [3:0] slot);
    logic [2:0] idx;
    idx = slot[2:0];
    bitPos = lsbFirst ? idx : 3'(3'h7 - idx);
  endfunction

  // quarter counter step: wraps to zero as each quarter ends
  function automatic logic [15:0] nextCount(input logic [15:0] cnt, input logic done);
    nextCount = done ? 16'h0000 : 16'(cnt + 16'h0001);
  endfunction

  // whether the host pulls data low during a byte slot
  function automatic logic bytePull(input logic isWrite, input logic ackRead,
                                    input logic [7:0] shift, input logic lsbFirst,
                                    input logic [3:0] slot);
    logic pullLow;
    pullLow = 1'b0;
    if (slot == prog_port_pkg::ACK_SLOT) begin
      // we acknowledge only bytes we received; a write leaves the slot to the device
      pullLow = !isWrite && ackRead;
    end else if (isWrite) begin
      pullLow = !shift[bitPos(lsbFirst, slot)];
    end
    bytePull = pullLow;
  endfunction

  // clock and pull levels for each quarter of each framing step
  function automatic logic [1:0] lineLevels(input prog_port_pkg::state_t st,
                                            input logic [1:0] ph, input logic bitPull);
    logic sckLvl;
    logic pullLvl;
    sckLvl = 1'b1;
    pullLvl = 1'b0;
    case (st)
      prog_port_pkg::ST_START: begin
        // release while low, raise clock, then drop data under a high clock
        sckLvl = (ph == prog_port_pkg::PH_RISE) || (ph == prog_port_pkg::PH_SAMPLE);
        pullLvl = (ph == prog_port_pkg::PH_SAMPLE) || (ph == prog_port_pkg::PH_FALL);
      end
      prog_port_pkg::ST_STOP: begin
        // pull low while clock low, raise clock, then release under a high clock
        sckLvl = (ph != prog_port_pkg::PH_SET);
        pullLvl = (ph == prog_port_pkg::PH_SET) || (ph == prog_port_pkg::PH_RISE);
      end
      prog_port_pkg::ST_BYTE: begin
        // data is set in the low quarter and held through the high ones
        sckLvl = (ph == prog_port_pkg::PH_RISE) || (ph == prog_port_pkg::PH_SAMPLE);
        pullLvl = bitPull;
      end
      default: begin
        sckLvl = 1'b1;
        pullLvl = 1'b0;
      end
    endcase
    lineLevels = {sckLvl, pullLvl};
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  logic quarterDone;
  logic [1:0] nextPhase;
  logic [1:0] lv;
  logic bitPullNext;

  always_comb begin
    s_d = s_q;
    lv = 2'b10;
    bitPullNext = 1'b0;
    quarterDone = (s_q.cnt == QUARTER_LAST);
    nextPhase = 2'(s_q.phase + 2'h1);
    s_d.respValid = 1'b0;
    // pin sampling: first flop feeds only the second
    s_d.sdaSync1 = progSerialDataIn;
    s_d.sdaSync2 = s_q.sdaSync1;
    // select follows the user level; holding it through a write cycle is the user's job
    s_d.selectN = !progEnable;
    case (s_q.state)
      prog_port_pkg::ST_IDLE: begin
        // idle keeps clock and data steady, as a running write cycle needs
        if (cmdValid) begin
          s_d.phase = prog_port_pkg::PH_SET;
          s_d.cnt = 16'h0000;
          s_d.waitCnt = 24'h000000;
          s_d.slot = prog_port_pkg::FIRST_SLOT;
          s_d.isWrite = (cmd.op == prog_port_pkg::OP_WRITE);
          s_d.lsbFirst = cmd.lsbFirst;
          s_d.ackRead = cmd.ackRead;
          s_d.shift = cmd.data;
          s_d.ackOk = 1'b0;
          case (cmd.op)
            prog_port_pkg::OP_START: s_d.state = prog_port_pkg::ST_START;
            prog_port_pkg::OP_STOP: s_d.state = prog_port_pkg::ST_STOP;
            prog_port_pkg::OP_WRITE: s_d.state = prog_port_pkg::ST_BYTE;
            prog_port_pkg::OP_READ: s_d.state = prog_port_pkg::ST_BYTE;
            prog_port_pkg::OP_WAIT: s_d.state = prog_port_pkg::ST_WAIT;
            default: s_d.state = prog_port_pkg::ST_IDLE;
          endcase
          // wait and unknown codes leave both lines exactly as they are
          if (s_d.state != prog_port_pkg::ST_WAIT && s_d.state != prog_port_pkg::ST_IDLE) begin
            bitPullNext = bytePull(s_d.isWrite, cmd.ackRead, cmd.data, cmd.lsbFirst,
                                   prog_port_pkg::FIRST_SLOT);
            lv = lineLevels(s_d.state, prog_port_pkg::PH_SET, bitPullNext);
            s_d.sck = lv[1];
            // a framing step drops the clock first and moves data a cycle later
            s_d.pull = (s_d.state == prog_port_pkg::ST_BYTE) ? lv[0] : s_q.pull;
          end
        end
      end

      prog_port_pkg::ST_START, prog_port_pkg::ST_STOP: begin
        s_d.cnt = nextCount(s_q.cnt, quarterDone);
        // data settles in the set quarter, one cycle after the clock fell
        if (s_q.phase == prog_port_pkg::PH_SET) begin
          lv = lineLevels(s_q.state, prog_port_pkg::PH_SET, 1'b0);
          s_d.pull = lv[0];
        end
        if (quarterDone) begin
          s_d.phase = nextPhase;
          if (s_q.phase == prog_port_pkg::PH_FALL) begin
            s_d.state = prog_port_pkg::ST_IDLE;
            s_d.respValid = 1'b1;
          end else begin
            lv = lineLevels(s_q.state, nextPhase, 1'b0);
            s_d.sck = lv[1];
            s_d.pull = lv[0];
          end
        end
      end

      prog_port_pkg::ST_BYTE: begin
        // one slot is four quarters; the ack slot is the ninth
        s_d.cnt = nextCount(s_q.cnt, quarterDone);
        // sample at the end of the second high quarter, two sync flops late
        if (quarterDone && s_q.phase == prog_port_pkg::PH_SAMPLE) begin
          if (s_q.slot == prog_port_pkg::ACK_SLOT) begin
            // low means accepted; a busy device leaves it high
            s_d.ackOk = s_q.isWrite ? !s_q.sdaSync2 : s_q.ackRead;
          end else if (!s_q.isWrite) begin
            s_d.shift[bitPos(s_q.lsbFirst, s_q.slot)] = s_q.sdaSync2;
          end
        end
        if (quarterDone) begin
          s_d.phase = nextPhase;
          if (s_q.phase == prog_port_pkg::PH_FALL) begin
            if (s_q.slot == prog_port_pkg::ACK_SLOT) begin
              // clock is left low, ready for another byte, a start or a stop
              s_d.state = prog_port_pkg::ST_IDLE;
              s_d.respValid = 1'b1;
              // hand the line back after our own acknowledge, clock still low
              s_d.pull = 1'b0;
            end else begin
              s_d.slot = 4'(s_q.slot + 4'h1);
              // ownership changes in the low quarter, well before the next rise
              bitPullNext = bytePull(s_q.isWrite, s_q.ackRead, s_d.shift, s_q.lsbFirst,
                                     s_d.slot);
              lv = lineLevels(s_q.state, nextPhase, bitPullNext);
              s_d.sck = lv[1];
              s_d.pull = lv[0];
            end
          end else begin
            lv = lineLevels(s_q.state, nextPhase, s_q.pull);
            s_d.sck = lv[1];
            s_d.pull = lv[0];
          end
        end
      end

      prog_port_pkg::ST_WAIT: begin
        // fixed wait is the fallback; polling with the address byte is quicker
        s_d.waitCnt = 24'(s_q.waitCnt + 24'h000001);
        if (s_q.waitCnt == WAIT_LAST) begin
          s_d.state = prog_port_pkg::ST_IDLE;
          s_d.respValid = 1'b1;
        end
      end

      default: begin
        // an illegal state code recovers to idle with released lines
        s_d.state = prog_port_pkg::ST_IDLE;
        s_d.phase = prog_port_pkg::PH_SET;
        s_d.cnt = 16'h0000;
        s_d.sck = prog_port_pkg::RST_SCK;
        s_d.pull = prog_port_pkg::RST_PULL;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.state <= prog_port_pkg::ST_IDLE;
      s_q.sck <= prog_port_pkg::RST_SCK;
      s_q.pull <= prog_port_pkg::RST_PULL;
      s_q.selectN <= prog_port_pkg::RST_SELECT_N;
      s_q.sdaSync1 <= prog_port_pkg::RST_SYNC;
      s_q.sdaSync2 <= prog_port_pkg::RST_SYNC;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign cmdReady = (s_q.state == prog_port_pkg::ST_IDLE);
  assign respValid = s_q.respValid;
  // one driver for the whole response; it stands until the next command is taken
  assign resp = {s_q.ackOk, s_q.shift};
  assign serialProgramSelectN = s_q.selectN;
  assign progSerialClock = s_q.sck;
  // open drain: the driven value is always low, only the enable moves
  assign progSerialDataOut = 1'b0;
  assign progSerialDataOeN = !s_q.pull;

endmodule

// >>> test/serial_prog_host_asserts.sv
// assertions on the serial programming host ports
// bound into every host instance; one clock domain
module serial_prog_host_asserts #(
  parameter int QUARTER = 5,
  parameter int WAIT_CYCLES = 20
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // user side
  input wire logic progEnable,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire prog_port_pkg::cmd_t cmd,
  input wire logic respValid,
  input wire prog_port_pkg::resp_t resp,
  // link pins
  input wire logic serialProgramSelectN,
  input wire logic progSerialClock,
  input wire logic progSerialDataIn,
  input wire logic progSerialDataOut,
  input wire logic progSerialDataOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EDGE_AT = 1 + 2 * QUARTER;
  localparam int BYTE_AT = 36 * QUARTER + 1;
  typedef struct packed {
    logic [2:0] op;
    logic ack;
    logic [15:0] cnt;
  } trk_t;
  trk_t trk_q, trk_d;
  logic take, rdOp, wrOp, ackSlot;
  assign take = cmdValid && cmdReady;
  // slot 8 begins once 32 quarters have run
  assign ackSlot = trk_q.cnt > 16'(32 * QUARTER);
  assign rdOp = trk_q.op == 3'h3 && !cmdReady;
  assign wrOp = trk_q.op == 3'h2 && !cmdReady;
  always_comb begin
    trk_d = trk_q;
    trk_d.cnt = trk_q.cnt + 16'h0001;
    if (take) begin
      trk_d = '{cmd.op, cmd.ackRead, 16'h0001};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trk_q <= '0;
    end else begin
      trk_q <= trk_d;
    end
  end
  ////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pull_only: assert property (progSerialDataOut == 1'b0)
    else $error("data line driven high");
  a_stable_high: assert property (
    (rdOp || wrOp) && progSerialClock && $past(progSerialClock) |-> $stable(progSerialDataOeN))
    else $error("data moved while clock high");
  a_start_fall: assert property (
    take && cmd.op == prog_port_pkg::OP_START |->
    ##EDGE_AT ($fell(progSerialDataOeN) && progSerialClock)) else $error("start misplaced");
  a_stop_rise: assert property (
    take && cmd.op == prog_port_pkg::OP_STOP |->
    ##EDGE_AT ($rose(progSerialDataOeN) && progSerialClock)) else $error("stop misplaced");
  a_byte_time: assert property (
    take && cmd.op[2:1] == 2'h1 |-> ##BYTE_AT respValid) else $error("byte length wrong");
  a_read_release: assert property (rdOp && !ackSlot |-> progSerialDataOeN)
    else $error("host drove device data");
  a_read_ack: assert property (
    rdOp && ackSlot |-> progSerialDataOeN == !trk_q.ack) else $error("read acknowledge wrong");
  a_write_ack: assert property (wrOp && ackSlot |-> progSerialDataOeN)
    else $error("host held acknowledge slot");
endmodule
bind serial_prog_host serial_prog_host_asserts #(.QUARTER(QUARTER), .WAIT_CYCLES(WAIT_CYCLES)) chk (
  .clk(clk), .rst_n(rst_n), .progEnable(progEnable), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .cmd(cmd), .respValid(respValid), .resp(resp),
  .serialProgramSelectN(serialProgramSelectN), .progSerialClock(progSerialClock),
  .progSerialDataIn(progSerialDataIn), .progSerialDataOut(progSerialDataOut),
  .progSerialDataOeN(progSerialDataOeN));

// >>> test/prog_device_model.sv
// behavioural configuration memory on the far end of the link
// sees the serial clock and the resolved data line; only pulls low
module prog_device_model #(
  parameter int BUSY_NS = 8000
) (
  // link
  input wire logic sck,
  input wire logic sda,
  input wire logic selectN,
  // open drain pull, high means line low
  output logic pull = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic [7:0] mem = 8'h00;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic busy = 1'b0;
  logic wrote = 1'b0;
  int bitN = 0;
  int byteN = 0;
  always @(negedge sda) if (sck && !busy && !selectN) begin
    act = 1'b1;
    rd = 1'b0;
    bitN = 0;
    byteN = 0;
    pull = 1'b0;
  end
  always @(posedge sda) if (sck && !busy && !selectN) begin
    act = 1'b0;
    if (wrote) begin
      wrote = 1'b0;
      busy = 1'b1;
      #BUSY_NS busy = 1'b0;
    end
  end
  always @(posedge sck) if (act && !busy && !selectN) begin
    if (bitN < 8) begin
      sh = (byteN == 0) ? {sh[6:0], sda} : {sda, sh[7:1]};
    end else if (rd && byteN > 0 && sda) begin
      act = 1'b0;
    end
    bitN = (bitN == 8) ? 0 : bitN + 1;
    byteN = (bitN == 0) ? byteN + 1 : byteN;
  end
  // drive only after a falling clock, so data never moves while high
  always @(negedge sck) if (act && !busy && !selectN) begin
    pull = 1'b0;
    if (bitN == 8 && (byteN == 0 || !rd)) begin
      pull = 1'b1;
      if (byteN == 0) begin
        rd = sh[0];
      end else begin
        mem = sh;
        wrote = 1'b1;
      end
    end else if (bitN < 8 && rd && byteN > 0) begin
      pull = !mem[bitN];
    end
  end
endmodule

// >>> test/testbench.sv
// self-checking bench for the serial programming host
// host and device model share one pulled-up data line
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 3;
  localparam int WC = 60;
  typedef struct packed {
    logic [2:0] op;
    logic lsb;
    logic ackRd;
    logic [7:0] d;
    logic ackExp;
    logic [7:0] rdExp;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic progEnable = 1'b1;
  logic cmdValid = 1'b0;
  prog_port_pkg::cmd_t cmd = '0;
  logic cmdReady, respValid, selN, sck, dOut, oeN, pull, sda;
  prog_port_pkg::resp_t resp;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  row_t rows[16];
  always #25 clk = ~clk;
  // open drain: low only when an enabled driver shows low; otherwise the pull-up wins
  assign sda = (oeN || dOut) && !pull;
  serial_prog_host #(.QUARTER(Q), .WAIT_CYCLES(WC)) dut (
    .clk(clk), .rst_n(rst_n), .progEnable(progEnable), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmd(cmd), .respValid(respValid), .resp(resp),
    .serialProgramSelectN(selN), .progSerialClock(sck), .progSerialDataIn(sda),
    .progSerialDataOut(dOut), .progSerialDataOeN(oeN));
  prog_device_model dev (.sck(sck), .sda(sda), .selectN(selN), .pull(pull));
  ////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [2:0] op, input logic lsb, input logic ackRd,
    input logic [7:0] d);
    cmd = '{prog_port_pkg::op_t'(op), lsb, ackRd, d};
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 cmdValid = 1'b0;
    n = 0;
    while (respValid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n = n + 1;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    // blank read, write, busy poll, wait, read back twice
    rows = '{'{3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00}, '{3'h2, 1'b0, 1'b0, 8'hA1, 1'b1, 8'h00},
      '{3'h3, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00}, '{3'h1, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00},
      '{3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00}, '{3'h2, 1'b0, 1'b0, 8'hA0, 1'b1, 8'h00},
      '{3'h2, 1'b1, 1'b0, 8'h5A, 1'b1, 8'h00}, '{3'h1, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00},
      '{3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00}, '{3'h2, 1'b0, 1'b0, 8'hA0, 1'b0, 8'h00},
      '{3'h4, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00}, '{3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00},
      '{3'h2, 1'b0, 1'b0, 8'hA1, 1'b1, 8'h00}, '{3'h3, 1'b1, 1'b1, 8'h00, 1'b1, 8'h5A},
      '{3'h3, 1'b1, 1'b0, 8'h00, 1'b0, 8'h5A}, '{3'h1, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00}};
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("select", 16'(selN), 16'h0000);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].lsb, rows[i].ackRd, rows[i].d);
      chk("ack", 16'(resp.ackOk), 16'(rows[i].ackExp));
      if (rows[i].op == 3'h3) chk("read", 16'(resp.data), 16'(rows[i].rdExp));
      chk("cycles", 16'(n), 16'(rows[i].op == 3'h4 ? WC : (rows[i].op == 3'h2
        || rows[i].op == 3'h3 ? 36 : 4) * Q));
    end
    // reset in mid byte, started by a held write request that is dropped with reset
    cmd = '{prog_port_pkg::OP_WRITE, 1'b0, 1'b0, 8'hA0};
    cmdValid = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b0;
    cmdValid = 1'b0;
    #1 chk("reset", 16'({cmdReady, respValid, sck, oeN, selN}), 16'h0017);
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 run(3'h0, 1'b0, 1'b0, 8'h00);
    run(3'h2, 1'b0, 1'b0, 8'hA0);
    chk("restart", 16'(resp.ackOk), 16'h0001);
    // an unknown code is taken and dropped, with no answer and no line movement
    cmd = '{prog_port_pkg::op_t'(3'h5), 1'b0, 1'b0, 8'h00};
    cmdValid = 1'b1;
    @(posedge clk);
    #1 cmdValid = 1'b0;
    chk("bad op", 16'({cmdReady, respValid, sck, oeN}), 16'h0009);
    run(3'h1, 1'b0, 1'b0, 8'h00);
    progEnable = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("deselect", 16'(selN), 16'h0001);
    complete_run();
  end
endmodule
